/* File: design/cev_exception_unit.sv */
// Exception entry, vector selection and priority logic with its AHB-Lite register file
`timescale 1ns/1ps
module cev_exception_unit #(
  parameter int TLB_ENTRIES = 64,
  parameter int VA_BITS     = 40
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire cev_pkg::cev_ahb_req_t ahb_i,
  output      cev_pkg::cev_ahb_rsp_t ahb_o,
  input  wire cev_pkg::cev_req_t exc_req,
  input  wire cev_pkg::cev_acc_t fetch_acc,
  input  wire cev_pkg::cev_acc_t data_acc,
  input  wire logic [7:0]       irq_lines,
  input  wire logic             nonmaskable_irq_n,
  input  wire logic             soft_reset_req,
  output      cev_pkg::cev_redir_t redir_o,
  output      logic [31:0]      status_o,
  output      logic [31:0]      cause_o,
  output      logic             bp_clear
);
  import cev_pkg::*;

  localparam int RW = $clog2(TLB_ENTRIES);
  localparam logic [RW-1:0] RANDOM_MAX = RW'(TLB_ENTRIES - 1);

  typedef struct packed {
    logic [31:0]   status;
    logic [31:0]   cause;
    logic [63:0]   exception_return_pc;
    logic [63:0]   errpc;
    logic [63:0]   badva;
    logic [19:0]   vbase;
    logic [4:0]    vs;
    logic [31:0]   config_w;
    logic [RW-1:0] random;
    logic [RW-1:0] wired;
    logic          probe_en;
    logic          perf_event;
    logic          boot_pend;
    logic          nmi_prev;
    logic          nmi_pend;
    logic          sreset_pend;
    cev_redir_t    redir;
    logic          bp_clear;
    logic          ap_valid;
    logic          ap_write;
    logic [7:0]    ap_addr;
    logic          rd_pend;
    logic [31:0]   hrdata;
  } cev_state_t;

  cev_state_t  s_reg;
  cev_state_t  s_next;
  logic [1:0]  mode;
  logic        fetch_ae;
  logic        data_ae;
  logic        int_ok;
  logic [2:0]  vec_no;
  logic        take;
  cev_cls_t    cls;
  logic [4:0]  code;
  logic        has_code;
  logic        bad_upd;
  logic [63:0] bad_val;
  logic [63:0] base;
  logic [11:0] off;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic logic [1:0] eff_mode(input logic [31:0] st);
    if (st[CEV_ST_EXL] | st[CEV_ST_ERL] | (st[CEV_ST_KSU +: 2] == CEV_KSU_KERNEL))
      return CEV_KSU_KERNEL;
    return st[CEV_ST_KSU +: 2];
  endfunction

  // Misaligned, illegal or privileged reference
  function automatic logic addr_fault(input cev_acc_t a, input logic [1:0] md);
    logic mis;
    logic compat;
    logic csseg;
    logic sup;
    logic ker;
    logic illeg;
    mis    = ((a.size == 2'h1) & a.addr[0]) | ((a.size == 2'h2) & (|a.addr[1:0]))
           | ((a.size == 2'h3) & (|a.addr[2:0]));
    compat = &a.addr[63:31];
    csseg  = compat & (a.addr[31:29] == 3'h6);
    sup    = (a.addr[63:62] == 2'h1) | csseg;
    ker    = (a.addr[63:62] == 2'h2) | ((a.addr[63:62] == 2'h3) & !csseg);
    illeg  = (!a.addr[63] & (|a.addr[61:VA_BITS]))
           | ((a.addr[63:62] == 2'h3) & !compat & !(&a.addr[61:VA_BITS]));
    return a.valid & (mis | illeg
           | ((md == CEV_KSU_USER) & (sup | ker)) | ((md == CEV_KSU_SUPER) & ker));
  endfunction

  // Highest pending line number
  function automatic logic [2:0] top_line(input logic [7:0] p);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (p[i])
        n = 3'(i);
    end
    return n;
  endfunction

  function automatic logic [31:0] read_reg(input cev_state_t st, input logic [7:0] a);
    if (a == CEV_R_STATUS)
      return st.status;
    else if (a == CEV_R_CAUSE)
      return st.cause;
    else if (a == CEV_R_EPC_LO)
      return st.exception_return_pc[31:0];
    else if (a == CEV_R_EPC_HI)
      return st.exception_return_pc[63:32];
    else if (a == CEV_R_ERR_LO)
      return st.errpc[31:0];
    else if (a == CEV_R_ERR_HI)
      return st.errpc[63:32];
    else if (a == CEV_R_BAD_LO)
      return st.badva[31:0];
    else if (a == CEV_R_BAD_HI)
      return st.badva[63:32];
    else if (a == CEV_R_VBASE)
      return {st.vbase, 12'h000};
    else if (a == CEV_R_INTERRUPT_CONTROL_REG)
      return {22'h000000, st.vs, 5'h00};
    else if (a == CEV_R_CONFIG)
      return st.config_w;
    else if (a == CEV_R_RANDOM)
      return {{(32 - RW){1'b0}}, st.random};
    else if (a == CEV_R_WIRED)
      return {{(32 - RW){1'b0}}, st.wired};
    else if (a == CEV_R_DEBUG)
      return {30'h00000000, st.perf_event, st.probe_en};
    return 32'h0000_0000;
  endfunction

  // --------------------------------------------------------------------------
  // Exception selection
  // --------------------------------------------------------------------------
  always_comb
  begin
    mode     = eff_mode(s_reg.status);
    fetch_ae = addr_fault(fetch_acc, mode);
    data_ae  = addr_fault(data_acc, mode);
    int_ok   = s_reg.status[CEV_ST_IE] & !s_reg.status[CEV_ST_EXL]
             & !s_reg.status[CEV_ST_ERL]
             & (|(s_reg.cause[CEV_CA_IP +: 8] & s_reg.status[CEV_ST_IM +: 8]));
    vec_no   = top_line(s_reg.cause[CEV_CA_IP +: 8] & s_reg.status[CEV_ST_IM +: 8]);
    cls      = CEV_CLS_NONE;
    code     = CEV_CODE_INT;
    has_code = 1'b1;
    bad_upd  = 1'b0;
    bad_val  = exc_req.tlb_addr;
    // Only the first match is reported
    if (s_reg.nmi_pend | s_reg.sreset_pend)
    begin
      cls = CEV_CLS_NMI;
      has_code = 1'b0;
    end
    else if (fetch_ae)
    begin
      cls = CEV_CLS_F_ADDR;
      code = CEV_CODE_LOAD_ADDR_FAULT;
      bad_upd = 1'b1;
      bad_val = fetch_acc.addr;
    end
    else if (exc_req.f_refill | exc_req.f_invalid)
    begin
      cls = exc_req.f_refill ? CEV_CLS_F_REFILL : CEV_CLS_F_INVALID;
      code = CEV_CODE_TLBL;
      bad_upd = 1'b1;
    end
    else if (exc_req.f_cache_err)
    begin
      cls = CEV_CLS_F_CACHE;
      has_code = 1'b0;
    end
    else if (exc_req.f_bus_err)
    begin
      cls = CEV_CLS_F_BUS;
      code = CEV_CODE_IBE;
    end
    else if (exc_req.instr_exc)
    begin
      cls = CEV_CLS_INSTR;
      code = exc_req.instr_code;
    end
    else if (exc_req.debug_irq)
    begin
      cls = CEV_CLS_DBG_INT;
      has_code = 1'b0;
    end
    else if (data_ae)
    begin
      cls = CEV_CLS_D_ADDR;
      code = data_acc.is_store ? CEV_CODE_STORE_ADDR_FAULT
                               : CEV_CODE_LOAD_ADDR_FAULT;
      bad_upd = 1'b1;
      bad_val = data_acc.addr;
    end
    else if (exc_req.d_refill | exc_req.d_invalid)
    begin
      cls = exc_req.d_refill ? CEV_CLS_D_REFILL : CEV_CLS_D_INVALID;
      code = exc_req.tlb_store ? CEV_CODE_TLBS : CEV_CODE_TLBL;
      bad_upd = 1'b1;
    end
    else if (exc_req.d_modify)
    begin
      cls = CEV_CLS_D_MOD;
      code = CEV_CODE_MOD;
      bad_upd = 1'b1;
    end
    else if (exc_req.d_bkpt)
    begin
      cls = CEV_CLS_D_BKPT;
      has_code = 1'b0;
    end
    else if (exc_req.d_cache_err)
    begin
      cls = CEV_CLS_D_CACHE;
      has_code = 1'b0;
    end
    else if (exc_req.d_bus_err)
    begin
      cls = CEV_CLS_D_BUS;
      code = CEV_CODE_DBE;
    end
    else if (int_ok)
    begin
      cls = CEV_CLS_INT;
    end
    // Base address
    if ((cls == CEV_CLS_F_CACHE) | (cls == CEV_CLS_D_CACHE))
      base = s_reg.status[CEV_ST_BEV] ? {CEV_UPPER_ONES, CEV_CER_BOOT_BASE}
           : {CEV_UPPER_ONES, s_reg.vbase[19:18], 1'b1, s_reg.vbase[16:0], 12'h000};
    else
      base = s_reg.status[CEV_ST_BEV] ? {CEV_UPPER_ONES, CEV_GEN_BOOT_BASE}
           : {CEV_UPPER_ONES, s_reg.vbase, 12'h000};
    // Offset
    off = CEV_OFF_COMMON;
    if (((cls == CEV_CLS_F_REFILL) | (cls == CEV_CLS_D_REFILL)) & !s_reg.status[CEV_ST_EXL])
      off = exc_req.wide_refill ? CEV_OFF_REFILL64 : CEV_OFF_REFILL32;
    else if ((cls == CEV_CLS_F_CACHE) | (cls == CEV_CLS_D_CACHE))
      off = CEV_OFF_CACHE_ERR;
    else if ((cls == CEV_CLS_INT) & s_reg.cause[CEV_CA_IV])
      off = CEV_OFF_VECT_INT + ({9'h000, vec_no} * {7'h00, s_reg.vs});
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.redir = '0;
    s_next.bp_clear = 1'b0;
    take = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;

    // Bus slave: writes in the data phase, reads one wait state later
    if (s_reg.ap_valid & s_reg.ap_write)
    begin
      if (s_reg.ap_addr == CEV_R_STATUS)
        s_next.status = ahb_i.hwdata;
      else if (s_reg.ap_addr == CEV_R_CAUSE)
        s_next.cause[CEV_CA_IV] = ahb_i.hwdata[CEV_CA_IV];
      else if (s_reg.ap_addr == CEV_R_EPC_LO)
        s_next.exception_return_pc[31:0] = ahb_i.hwdata;
      else if (s_reg.ap_addr == CEV_R_EPC_HI)
        s_next.exception_return_pc[63:32] = ahb_i.hwdata;
      else if (s_reg.ap_addr == CEV_R_ERR_LO)
        s_next.errpc[31:0] = ahb_i.hwdata;
      else if (s_reg.ap_addr == CEV_R_ERR_HI)
        s_next.errpc[63:32] = ahb_i.hwdata;
      else if (s_reg.ap_addr == CEV_R_VBASE)
        s_next.vbase = ahb_i.hwdata[31:12];
      else if (s_reg.ap_addr == CEV_R_INTERRUPT_CONTROL_REG)
        s_next.vs = ahb_i.hwdata[CEV_IC_VS +: 5];
      else if (s_reg.ap_addr == CEV_R_CONFIG)
        s_next.config_w[2:0] = ahb_i.hwdata[2:0];
      else if (s_reg.ap_addr == CEV_R_WIRED)
        s_next.wired = ahb_i.hwdata[RW-1:0];
      else if (s_reg.ap_addr == CEV_R_DEBUG)
        {s_next.perf_event, s_next.probe_en} = ahb_i.hwdata[1:0];
    end
    if (s_reg.rd_pend)
    begin
      s_next.hrdata = read_reg(s_reg, s_reg.ap_addr);
      s_next.rd_pend = 1'b0;
    end
    if (take)
    begin
      s_next.ap_valid = (ahb_i.hsize == 3'h2) | !ahb_i.hwrite;
      s_next.ap_write = ahb_i.hwrite;
      s_next.ap_addr = ahb_i.haddr[7:0];
      s_next.rd_pend = !ahb_i.hwrite;
    end
    else if (ahb_i.hready)
      s_next.ap_valid = 1'b0;

    // Random index counts down from the maximum to the wired count
    s_next.random = (s_reg.random <= s_reg.wired) ? RANDOM_MAX : s_reg.random - 1'b1;
    s_next.cause[CEV_CA_IP +: 8] = irq_lines;

    // NMI falls low, soft reset pulses; both wait for a boundary
    s_next.nmi_prev = nonmaskable_irq_n;
    if (s_reg.nmi_prev & !nonmaskable_irq_n)
      s_next.nmi_pend = 1'b1;
    if (soft_reset_req)
      s_next.sreset_pend = 1'b1;

    if (s_reg.boot_pend)
    begin
      s_next.boot_pend = 1'b0;
      s_next.errpc = exc_req.pc;
      s_next.bp_clear = 1'b1;
    end
    else if (exc_req.commit & (cls == CEV_CLS_NMI))
    begin
      // Cause, exception PC and bad address untouched
      s_next.nmi_pend = s_reg.nmi_prev & !nonmaskable_irq_n;
      s_next.sreset_pend = soft_reset_req;
      s_next.errpc = exc_req.pc;
      s_next.status[CEV_ST_ERL] = 1'b1;
      s_next.status[CEV_ST_SR] = 1'b1;
      s_next.status[CEV_ST_BEV] = 1'b1;
      s_next.redir.valid = 1'b1;
      s_next.redir.bypass = 1'b1;
      s_next.redir.cls = cls;
      s_next.redir.target = s_reg.status[CEV_ST_KX] ? CEV_RESET_VEC64
                                                   : CEV_RESET_VEC32;
    end
    else if (exc_req.commit & ((cls == CEV_CLS_DBG_INT) | (cls == CEV_CLS_D_BKPT)))
    begin
      s_next.redir.valid = 1'b1;
      s_next.redir.cls = cls;
      s_next.redir.target = {CEV_UPPER_ONES,
                             s_reg.probe_en ? CEV_DBG_PROBE_ON : CEV_DBG_PROBE_OFF};
    end
    else if (exc_req.commit & (cls != CEV_CLS_NONE))
    begin
      // All of these land on the same edge as the redirect
      if (!s_reg.status[CEV_ST_EXL])
      begin
        s_next.exception_return_pc = exc_req.in_delay_slot ? exc_req.branch_pc : exc_req.pc;
        s_next.cause[CEV_CA_BD] = exc_req.in_delay_slot;
      end
      if (has_code)
        s_next.cause[CEV_CA_CODE +: 5] = code;
      if (bad_upd)
        s_next.badva = bad_val;
      s_next.status[CEV_ST_EXL] = 1'b1;
      s_next.redir.valid = 1'b1;
      s_next.redir.cls = cls;
      s_next.redir.target = base + {52'h0000000000000, off};
    end
    else if (exc_req.commit & exc_req.eret)
    begin
      s_next.redir.valid = 1'b1;
      s_next.redir.eret = 1'b1;
      if (s_reg.status[CEV_ST_ERL])
      begin
        s_next.status[CEV_ST_ERL] = 1'b0;
        s_next.redir.target = s_reg.errpc;
      end
      else
      begin
        s_next.status[CEV_ST_EXL] = 1'b0;
        s_next.redir.target = s_reg.exception_return_pc;
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_reg <= '0;
      s_reg.status <= CEV_STATUS_RST;
      s_reg.config_w <= CEV_CONFIG_RST;
      s_reg.random <= RANDOM_MAX;
      s_reg.wired <= '0;
      s_reg.boot_pend <= 1'b1;
      s_reg.nmi_prev <= 1'b1;
      s_reg.redir.valid <= 1'b1;
      s_reg.redir.bypass <= 1'b1;
      s_reg.redir.cls <= CEV_CLS_COLD;
      s_reg.redir.target <= CEV_RESET_VEC64;
    end
    else
      s_reg <= s_next;
  end

  assign ahb_o.hreadyout = !s_reg.rd_pend;
  assign ahb_o.hresp = 1'b0;
  assign ahb_o.hrdata = s_reg.hrdata;
  assign redir_o = s_reg.redir;
  assign status_o = s_reg.status;
  assign cause_o = s_reg.cause;
  assign bp_clear = s_reg.bp_clear;

endmodule // cev_exception_unit

/* File: design/cev_pkg.sv */
// Constants, carriers and enumerations of the exception vectoring unit
// What this block does
// - Taking any exception except cold reset, NMI, soft reset, debug interrupt or data breakpoint sets the exception level flag, entering kernel mode.
// - An exception return clears the error level flag if set, otherwise the exception level flag.
// - Cold reset, soft reset and NMI jump to the fixed reset address, no offset.
// - Reset vector fetches bypass cache and address translation.
// - Debug entry address is chosen by the probe enable flag.
// - General base: ones, base field 31..12, zeros; boot vector uses fixed base.
// - Offsets: refill 0x000 or 0x080, cache error 0x100, others 0x180.
// - Vectored interrupts use 0x200 plus vector number times spacing field.
// - Each interrupt line has its own entry; line 7 wins over line 0.
// - Several simultaneous exceptions report only the highest priority one.
// - Priority order runs from cold reset down to interrupts as listed.
// - Cold reset loads status 0x30C000E4: soft reset clear, error level and boot set.
// - Cold reset loads configuration register 0x80034482.
// - Cold reset sets random index to maximum and wired count to zero.
// - Cold reset captures PC, clears event bit, breakpoints and pending interrupts.
// - Falling NMI input raises NMI at an instruction boundary; cause left unchanged.
// - NMI or soft reset keeps registers, saves PC, sets three flags, jumps to reset.
// - Address error on illegal space, privilege violation or misaligned access.
// - Address errors use the shared vector with load or store fault code.
// - Address error captures the offending virtual address.
// - Exception PC holds the faulting or branch address; delay slot flag set.
// - Dedicated refill offsets only apply while the exception level flag is clear.
// - Refill offset follows the width of the faulting reference.
package cev_pkg;

  localparam logic [63:0] CEV_RESET_VEC64   = 64'hFFFF_FFFF_BFC0_0000;
  localparam logic [63:0] CEV_RESET_VEC32   = 64'h0000_0000_BFC0_0000;
  localparam logic [31:0] CEV_UPPER_ONES    = 32'hFFFF_FFFF;
  localparam logic [31:0] CEV_DBG_PROBE_OFF = 32'hBFC0_0480;
  localparam logic [31:0] CEV_DBG_PROBE_ON  = 32'hFF20_0200;
  localparam logic [31:0] CEV_GEN_BOOT_BASE = 32'hBFC0_0200;
  localparam logic [31:0] CEV_CER_BOOT_BASE = 32'hBFC0_0300;
  localparam logic [11:0] CEV_OFF_REFILL32  = 12'h000;
  localparam logic [11:0] CEV_OFF_REFILL64  = 12'h080;
  localparam logic [11:0] CEV_OFF_CACHE_ERR = 12'h100;
  localparam logic [11:0] CEV_OFF_COMMON    = 12'h180;
  localparam logic [11:0] CEV_OFF_VECT_INT  = 12'h200;
  localparam logic [31:0] CEV_STATUS_RST    = 32'h30C0_00E4;
  localparam logic [31:0] CEV_CONFIG_RST    = 32'h8003_4482;
  // Status and cause field positions
  localparam int CEV_ST_IE  = 0;
  localparam int CEV_ST_EXL = 1;
  localparam int CEV_ST_ERL = 2;
  localparam int CEV_ST_KSU = 3;
  localparam int CEV_ST_KX  = 7;
  localparam int CEV_ST_IM  = 8;
  localparam int CEV_ST_SR  = 20;
  localparam int CEV_ST_BEV = 22;
  localparam int CEV_CA_CODE = 2;
  localparam int CEV_CA_IP   = 8;
  localparam int CEV_CA_IV   = 23;
  localparam int CEV_CA_BD   = 31;
  localparam int CEV_IC_VS   = 5;
  localparam logic [1:0] CEV_KSU_KERNEL = 2'h0;
  localparam logic [1:0] CEV_KSU_SUPER  = 2'h1;
  localparam logic [1:0] CEV_KSU_USER   = 2'h2;
  // Cause codes
  localparam logic [4:0] CEV_CODE_INT  = 5'h00;
  localparam logic [4:0] CEV_CODE_MOD  = 5'h01;
  localparam logic [4:0] CEV_CODE_TLBL = 5'h02;
  localparam logic [4:0] CEV_CODE_TLBS = 5'h03;
  localparam logic [4:0] CEV_CODE_LOAD_ADDR_FAULT  = 5'h04;
  localparam logic [4:0] CEV_CODE_STORE_ADDR_FAULT = 5'h05;
  localparam logic [4:0] CEV_CODE_IBE  = 5'h06;
  localparam logic [4:0] CEV_CODE_DBE  = 5'h07;
  // Register byte offsets
  localparam logic [7:0] CEV_R_STATUS = 8'h00;
  localparam logic [7:0] CEV_R_CAUSE  = 8'h04;
  localparam logic [7:0] CEV_R_EPC_LO = 8'h08;
  localparam logic [7:0] CEV_R_EPC_HI = 8'h0C;
  localparam logic [7:0] CEV_R_ERR_LO = 8'h10;
  localparam logic [7:0] CEV_R_ERR_HI = 8'h14;
  localparam logic [7:0] CEV_R_BAD_LO = 8'h18;
  localparam logic [7:0] CEV_R_BAD_HI = 8'h1C;
  localparam logic [7:0] CEV_R_VBASE  = 8'h20;
  localparam logic [7:0] CEV_R_INTERRUPT_CONTROL_REG = 8'h24;
  localparam logic [7:0] CEV_R_CONFIG = 8'h28;
  localparam logic [7:0] CEV_R_RANDOM = 8'h2C;
  localparam logic [7:0] CEV_R_WIRED  = 8'h30;
  localparam logic [7:0] CEV_R_DEBUG  = 8'h34;

  typedef enum logic [4:0] {
    CEV_CLS_NONE, CEV_CLS_COLD, CEV_CLS_NMI, CEV_CLS_F_ADDR, CEV_CLS_F_REFILL,
    CEV_CLS_F_INVALID, CEV_CLS_F_CACHE, CEV_CLS_F_BUS, CEV_CLS_INSTR, CEV_CLS_DBG_INT,
    CEV_CLS_D_ADDR, CEV_CLS_D_REFILL, CEV_CLS_D_INVALID, CEV_CLS_D_MOD, CEV_CLS_D_BKPT,
    CEV_CLS_D_CACHE, CEV_CLS_D_BUS, CEV_CLS_INT
  } cev_cls_t;

  typedef struct packed {
    logic        commit;
    logic        eret;
    logic [63:0] pc;
    logic        in_delay_slot;
    logic [63:0] branch_pc;
    logic        f_refill;
    logic        f_invalid;
    logic        f_cache_err;
    logic        f_bus_err;
    logic        instr_exc;
    logic [4:0]  instr_code;
    logic        debug_irq;
    logic        d_refill;
    logic        d_invalid;
    logic        d_modify;
    logic        d_bkpt;
    logic        d_cache_err;
    logic        d_bus_err;
    logic        tlb_store;
    logic        wide_refill;
    logic [63:0] tlb_addr;
  } cev_req_t;

  typedef struct packed {
    logic        valid;
    logic        is_store;
    logic [1:0]  size;
    logic [63:0] addr;
  } cev_acc_t;

  typedef struct packed {
    logic        valid;
    logic        eret;
    logic        bypass;
    cev_cls_t    cls;
    logic [63:0] target;
  } cev_redir_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } cev_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } cev_ahb_rsp_t;

endpackage

/* File: dv/cev_asserts.sv */
// Port checks of the exception vectoring unit
`timescale 1ns/1ps
module cev_asserts
  import cev_pkg::*;
(
  input wire logic                clk_sys,
  input wire logic                resetn,
  input wire cev_pkg::cev_req_t   exc_req,
  input wire cev_pkg::cev_acc_t   data_acc,
  input wire cev_pkg::cev_redir_t redir_o,
  input wire logic [31:0]         status_o,
  input wire logic [31:0]         cause_o,
  input wire logic                bp_clear
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic     rv;
  cev_cls_t rc;
  assign rv = redir_o.valid;
  assign rc = redir_o.cls;
  chk_exl_on_entry: assert property (rv && !redir_o.eret
    && !(rc inside {CEV_CLS_COLD, CEV_CLS_NMI, CEV_CLS_DBG_INT, CEV_CLS_D_BKPT}) |-> status_o[1])
    else $error("exception level flag not set on entry");
  chk_eret_clears: assert property (rv && redir_o.eret |-> !status_o[1])
    else $error("exception level flag not cleared by return");
  chk_reset_vector: assert property (rv && rc inside {CEV_CLS_COLD, CEV_CLS_NMI} |->
    redir_o.bypass && redir_o.target == (status_o[7] ? 64'hFFFF_FFFF_BFC0_0000 : 64'hBFC0_0000))
    else $error("reset class left the reset vector");
  chk_debug_entry: assert property (rv && rc == CEV_CLS_DBG_INT |->
    redir_o.target[31:0] inside {32'hBFC0_0480, 32'hFF20_0200})
    else $error("debug entry address wrong");
  chk_refill_offset: assert property (rv && rc == CEV_CLS_D_REFILL |->
    redir_o.target[8:0] == ($past(status_o[1]) ? 9'h180 : $past(exc_req.wide_refill) ? 9'h080 : 9'h000))
    else $error("refill offset wrong");
  chk_addr_code: assert property (rv && rc == CEV_CLS_D_ADDR |-> redir_o.target[8:0] == 9'h180
    && cause_o[6:2] == ($past(data_acc.is_store) ? 5'h05 : 5'h04))
    else $error("address fault code or vector wrong");
  chk_nmi_flags: assert property (rv && rc == CEV_CLS_NMI |-> status_o[2] && status_o[20]
    && status_o[22] && cause_o[6:2] == $past(cause_o[6:2]))
    else $error("nmi state wrong");
  chk_cold_state: assert property (disable iff (1'b0)
    $rose(resetn) |-> status_o == 32'h30C0_00E4 ##1 bp_clear)
    else $error("cold reset state wrong");
  cover property (rv && rc == CEV_CLS_NMI);
  cover property (rv && rc == CEV_CLS_D_ADDR);
  cover property (rv && redir_o.eret);
endmodule // cev_asserts

bind cev_exception_unit cev_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .exc_req(exc_req),
  .data_acc(data_acc), .redir_o(redir_o), .status_o(status_o), .cause_o(cause_o), .bp_clear(bp_clear));

/* File: dv/cev_pipe_model.sv */
// Pipeline model that follows redirects with its fetch PC
`timescale 1ns/1ps
module cev_pipe_model
  import cev_pkg::*;
(
  input wire logic                clk_sys,
  input wire logic                resetn,
  input wire cev_pkg::cev_redir_t redir_i,
  output     logic [63:0]         pc
);
  // Fetch resumes at each redirect target
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      pc <= 64'hFFFF_FFFF_BFC0_0000;
    else if (redir_i.valid)
      pc <= redir_i.target;
  end
endmodule // cev_pipe_model

/* File: dv/cpu_exception_vectoring_tb_top.sv */
// Self-checking bench of the exception vectoring unit
`timescale 1ns/1ps
module cpu_exception_vectoring_tb_top;
  import cev_pkg::*;
  logic         clk_sys;
  logic         resetn;
  cev_ahb_req_t bus_q;
  cev_ahb_req_t ahb_w;
  cev_ahb_rsp_t ahb_o;
  cev_req_t     exc_req;
  cev_acc_t     fetch_acc;
  cev_acc_t     data_acc;
  logic [7:0]   irq_lines;
  logic         nonmaskable_irq_n;
  logic         soft_reset_req;
  cev_redir_t   redir_o;
  logic [31:0]  status_o;
  logic [31:0]  cause_o;
  logic         bp_clear;
  logic [63:0]  pc_m;
  int           n_errors = 0;
  int           checks = 0;
  always_comb
  begin
    ahb_w = bus_q;
    ahb_w.hready = ahb_o.hreadyout;
  end
  cev_exception_unit dut (.clk_sys(clk_sys), .resetn(resetn), .ahb_i(ahb_w), .ahb_o(ahb_o),
    .exc_req(exc_req), .fetch_acc(fetch_acc), .data_acc(data_acc), .irq_lines(irq_lines),
    .nonmaskable_irq_n(nonmaskable_irq_n), .soft_reset_req(soft_reset_req), .redir_o(redir_o),
    .status_o(status_o), .cause_o(cause_o), .bp_clear(bp_clear));
  cev_pipe_model u_pipe (.clk_sys(clk_sys), .resetn(resetn), .redir_i(redir_o), .pc(pc_m));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single word transfer; address held until taken, data until answered
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    bus_q <= '{1'b1, {24'h0, a}, 2'h2, w, 3'h2, ~d, 1'b1};
    do @(posedge clk_sys); while (ahb_o.hreadyout !== 1'b1);
    bus_q <= '{1'b1, {24'h0, a}, 2'h0, w, 3'h2, d, 1'b1};
    do @(posedge clk_sys); while (ahb_o.hreadyout !== 1'b1);
    r = ahb_o.hrdata;
    bus_q <= '{1'b0, 32'h0, 2'h0, 1'b0, 3'h2, ~d, 1'b1};
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(n, {32'h0, e}, {32'h0, r});
  endtask
  // Commit one instruction boundary and check the redirect that follows
  task automatic fire(input cev_req_t q, input logic [63:0] t, input cev_cls_t c);
    q.commit = 1'b1;
    @(posedge clk_sys);
    #1;
    q.pc = pc_m;
    @(posedge clk_sys);
    exc_req <= q;
    @(posedge clk_sys);
    exc_req <= '0;
    #1;
    chk("redirect valid", 64'h1, {63'h0, redir_o.valid});
    if (c != CEV_CLS_NONE)
    begin
      chk("target", t, redir_o.target);
      chk("class", {59'h0, c}, {59'h0, redir_o.cls});
    end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end
  initial
  begin
    bus_q = '0;
    exc_req = '0;
    exc_req.pc = 64'hFFFF_FFFF_BFC0_0000;
    fetch_acc = '0;
    data_acc = '0;
    irq_lines = 8'h00;
    nonmaskable_irq_n = 1'b1;
    soft_reset_req = 1'b0;
    resetn = 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd("status", CEV_R_STATUS, 32'h30C0_00E4);
    rd("config", CEV_R_CONFIG, 32'h8003_4482);
    rd("wired", CEV_R_WIRED, 32'h0000_0000);
    rd("errpc hi", CEV_R_ERR_HI, 32'hFFFF_FFFF);
    rd("errpc lo", CEV_R_ERR_LO, 32'hBFC0_0000);
    rd("unmapped", 8'h3C, 32'h0000_0000);
    fire('{d_invalid:1'b1, default:'0}, 64'hFFFF_FFFF_BFC0_0380, CEV_CLS_D_INVALID);
    $display("test reset and boot vector done");
    wr(CEV_R_STATUS, 32'h0000_0080);
    wr(CEV_R_VBASE, 32'h1234_5000);
    fire('{d_refill:1'b1, wide_refill:1'b1, default:'0}, 64'hFFFF_FFFF_1234_5080, CEV_CLS_D_REFILL);
    fire('{d_refill:1'b1, default:'0}, 64'hFFFF_FFFF_1234_5180, CEV_CLS_D_REFILL);
    fire('{eret:1'b1, default:'0}, 64'h0, CEV_CLS_NONE);
    rd("status after return", CEV_R_STATUS, 32'h0000_0080);
    $display("test refill done");
    @(posedge clk_sys);
    data_acc <= '{1'b1, 1'b1, 2'h2, 64'hFFFF_FFFF_8000_1002};
    fire('{in_delay_slot:1'b1, branch_pc:64'hFFFF_FFFF_8000_0FFC, default:'0},
      64'hFFFF_FFFF_1234_5180, CEV_CLS_D_ADDR);
    @(posedge clk_sys);
    data_acc <= '0;
    rd("cause", CEV_R_CAUSE, 32'h8000_0014);
    rd("bad address", CEV_R_BAD_LO, 32'h8000_1002);
    rd("epc", CEV_R_EPC_LO, 32'h8000_0FFC);
    $display("test address error done");
    fire('{f_bus_err:1'b1, d_refill:1'b1, default:'0}, 64'hFFFF_FFFF_1234_5180, CEV_CLS_F_BUS);
    fire('{f_cache_err:1'b1, f_bus_err:1'b1, default:'0},
      64'hFFFF_FFFF_3234_5100, CEV_CLS_F_CACHE);
    wr(CEV_R_DEBUG, 32'h0000_0001);
    fire('{debug_irq:1'b1, d_bus_err:1'b1, default:'0}, 64'hFFFF_FFFF_FF20_0200, CEV_CLS_DBG_INT);
    $display("test priority done");
    wr(CEV_R_INTERRUPT_CONTROL_REG, 32'h0000_0040);
    wr(CEV_R_CAUSE, 32'h0080_0000);
    @(posedge clk_sys);
    irq_lines <= 8'h28;
    wr(CEV_R_STATUS, 32'h0000_2881);
    fire('{default:'0}, 64'hFFFF_FFFF_1234_520A, CEV_CLS_INT);
    @(posedge clk_sys);
    irq_lines <= 8'h00;
    $display("test vectored interrupt done");
    @(posedge clk_sys);
    nonmaskable_irq_n <= 1'b0;
    fire('{default:'0}, 64'hFFFF_FFFF_BFC0_0000, CEV_CLS_NMI);
    @(posedge clk_sys);
    nonmaskable_irq_n <= 1'b1;
    rd("status after nmi", CEV_R_STATUS, 32'h0050_2887);
    rd("cause after nmi", CEV_R_CAUSE, 32'h0080_0000);
    rd("errpc after nmi", CEV_R_ERR_LO, 32'h1234_520A);
    @(posedge clk_sys);
    soft_reset_req <= 1'b1;
    @(posedge clk_sys);
    soft_reset_req <= 1'b0;
    fire('{default:'0}, 64'hFFFF_FFFF_BFC0_0000, CEV_CLS_NMI);
    rd("errpc after soft reset", CEV_R_ERR_LO, 32'hBFC0_0000);
    $display("test nmi done");
    wrap_up();
  end
endmodule // cpu_exception_vectoring_tb_top
